// ### hdl/sfd_regs.svh
`ifndef SFD_REGS_SVH
`define SFD_REGS_SVH

// Data port alias window, byte addresses on the register bus
`define SFD_ADDR_W          8
`define SFD_DATA_BASE       8'h60
`define SFD_ALIAS_COUNT     36
`define SFD_ALIAS_STRIDE    8'h04
`define SFD_FIFO_ALIAS_2    8'h68
`define SFD_FIFO_ALIAS_3    8'h6c
`define SFD_FIFO_ALIAS_4    8'h70
`define SFD_FIFO_ALIAS_5    8'h74
`define SFD_FIFO_ALIAS_8    8'h80

// Field layout of every alias location
`define SFD_FIELD_MSB       15
`define SFD_FIELD_LSB       0
`define SFD_FIELD_W         16
`define SFD_UPPER_MSB       31
`define SFD_UPPER_LSB       16
`define SFD_FIELD_RESET     16'h0000
`define SFD_WORD_RESET      32'h0000_0000

`endif

// ### hdl/sfd_pkg.sv
package sfd_pkg;

    typedef enum logic {
        SFD_PH_IDLE,
        SFD_PH_ACCESS
    } sfd_phase_t;

    typedef logic [15:0] sfd_field_t;
    typedef logic [31:0] sfd_word_t;

endpackage

// ### hdl/sfd_fifo.sv
module sfd_fifo
    import sfd_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic                         mclk,
    input  wire logic                         rst_n,
    input  wire logic                         flush,
    input  wire logic                         push,
    input  wire logic [WIDTH-1:0]             push_data,
    input  wire logic                         pop,
    output logic      [WIDTH-1:0]             head,
    output logic                              full,
    output logic                              empty,
    output logic      [$clog2(DEPTH+1)-1:0]   level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH+1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem      [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [LW-1:0]    next_level;
    logic             do_push;
    logic             do_pop;

    // Pointers wrap at DEPTH so that a depth that is not a power of two works
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == LAST) ? '0 : p + 1'b1;
    endfunction

    assign full    = (level == LW'(DEPTH));
    assign empty   = (level == '0);
    assign head    = mem[rd_ptr];
    // Overflow and underflow are dropped, never wrapped into old data
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_level  = level;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_level  = '0;
        end else begin
            if (do_push) begin
                next_mem[wr_ptr] = push_data;
                next_wr_ptr      = bump(wr_ptr);
            end
            if (do_pop) begin
                next_rd_ptr = bump(rd_ptr);
            end
            if (do_push && !do_pop) begin
                next_level = level + 1'b1;
            end else if (do_pop && !do_push) begin
                next_level = level - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            level  <= next_level;
            mem    <= next_mem;
        end
    end

endmodule

// ### hdl/sfd_data_port.sv
`include "sfd_regs.svh"
// What this block does
// - One 16-bit data port reaches both the transmit and the receive FIFO.
// - A bus read returns the oldest receive entry and removes it.
// - A bus write appends the written value to the transmit FIFO tail.
// - Transmit pushes only happen while the controller enable is 1.
// - While the enable is 0 both FIFOs are held empty.
// - The data port answers at thirty-six consecutive word locations.
// - A write to any alias location pushes the write data into transmit.
// - A read from any alias location pops the next receive entry.
// - FIFO entries are reachable only by sequential push and pop.
// - Data is right-justified in the 16-bit field both ways.
module sfd_data_port
    import sfd_pkg::*;
#(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    input  wire logic                           mclk,
    input  wire logic                           rst_n,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [`SFD_ADDR_W-1:0]         paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           ctrl_enable,
    input  wire logic                           tx_pop,
    output logic      [`SFD_FIELD_W-1:0]        tx_data,
    output logic                                tx_empty,
    output logic      [$clog2(TX_DEPTH+1)-1:0]  tx_level,
    input  wire logic                           rx_push,
    input  wire logic [`SFD_FIELD_W-1:0]        rx_data,
    output logic                                rx_full,
    output logic      [$clog2(RX_DEPTH+1)-1:0]  rx_level
);
    localparam logic [`SFD_ADDR_W-1:0] WIN_END =
        `SFD_ADDR_W'(`SFD_DATA_BASE + `SFD_ALIAS_COUNT * `SFD_ALIAS_STRIDE);

    sfd_phase_t  phase;
    sfd_phase_t  next_phase;
    sfd_word_t   next_prdata;
    logic        rd_valid;
    logic        next_rd_valid;
    sfd_field_t  rx_head;
    logic        tx_full;
    logic        rx_empty;
    logic        flush;
    logic        setup_rd;
    logic        access;
    logic        hit;
    logic        tx_push;
    logic        rx_pop;

    // Every aligned word of the window decodes the same way
    function automatic logic in_window(input logic [`SFD_ADDR_W-1:0] a);
        return (a >= `SFD_DATA_BASE) && (a < WIN_END) && (a[1:0] == 2'b00);
    endfunction

    assign hit      = in_window(paddr);
    assign access   = psel && penable;
    assign setup_rd = psel && !penable && !pwrite && hit;
    assign flush    = !ctrl_enable;
    // Zero wait states; out-of-window words are refused with an error
    assign pready   = 1'b1;
    assign pslverr  = access && !hit;
    // Upper bits of the write data never reach the FIFO
    assign tx_push  = access && pwrite && hit && ctrl_enable;
    // Pop only what was captured in setup, so data and pop always agree
    assign rx_pop   = access && !pwrite && (phase == SFD_PH_ACCESS) && rd_valid;

    sfd_fifo #(
        .WIDTH     (`SFD_FIELD_W),
        .DEPTH     (TX_DEPTH)
    ) u_tx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .flush     (flush),
        .push      (tx_push),
        .push_data (pwdata[`SFD_FIELD_MSB:`SFD_FIELD_LSB]),
        .pop       (tx_pop),
        .head      (tx_data),
        .full      (tx_full),
        .empty     (tx_empty),
        .level     (tx_level)
    );

    sfd_fifo #(
        .WIDTH     (`SFD_FIELD_W),
        .DEPTH     (RX_DEPTH)
    ) u_rx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .flush     (flush),
        .push      (rx_push && ctrl_enable),
        .push_data (rx_data),
        .pop       (rx_pop),
        .head      (rx_head),
        .full      (rx_full),
        .empty     (rx_empty),
        .level     (rx_level)
    );

    always_comb begin
        next_phase    = phase;
        next_prdata   = prdata;
        next_rd_valid = rd_valid;
        if (psel && !penable) begin
            next_phase = SFD_PH_ACCESS;
        end else if (!psel || penable) begin
            next_phase = SFD_PH_IDLE;
        end
        if (setup_rd) begin
            // Empty receive FIFO reads as zero and pops nothing
            next_rd_valid = !rx_empty && ctrl_enable;
            next_prdata   = (!rx_empty && ctrl_enable) ?
                            {16'h0000, rx_head} : `SFD_WORD_RESET;
        end else if (psel && !penable) begin
            next_rd_valid = 1'b0;
            next_prdata   = `SFD_WORD_RESET;
        end else if (access) begin
            next_rd_valid = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase    <= SFD_PH_IDLE;
            prdata   <= `SFD_WORD_RESET;
            rd_valid <= 1'b0;
        end else begin
            phase    <= next_phase;
            prdata   <= next_prdata;
            rd_valid <= next_rd_valid;
        end
    end

    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence s_setup_rd_data;
        setup_rd && !rx_empty && ctrl_enable;
    endsequence

    sequence s_access_rd;
        psel && penable && !pwrite;
    endsequence

    sequence s_push_empty_tx;
        tx_push && tx_empty && !tx_pop;
    endsequence

    property p_read_pops;
        s_setup_rd_data ##1 (s_access_rd and (ctrl_enable && !rx_push))
            |=> rx_level == $past(rx_level) - 1'b1;
    endproperty

    property p_read_value;
        s_setup_rd_data ##1 s_access_rd |-> prdata == {16'h0000, $past(rx_head)};
    endproperty

    read_pops_a: assert property (p_read_pops)
        else $error("read of a filled receive FIFO did not pop");

    read_value_a: assert property (p_read_value)
        else $error("read data is not the oldest receive entry");

    tx_push_a: assert property (
        tx_push && !tx_full && !tx_pop |=> tx_level == $past(tx_level) + 1'b1)
        else $error("write to the data port did not push");

    tx_value_a: assert property (
        s_push_empty_tx |=> !tx_empty && tx_data == $past(pwdata[15:0]))
        else $error("transmit head differs from written field");

    alias_write_a: assert property (
        psel && penable && pwrite && hit && ctrl_enable && !tx_full && !tx_pop
            |=> !tx_empty)
        else $error("alias write left transmit FIFO empty");

    disabled_write_a: assert property (
        psel && penable && pwrite && !ctrl_enable |=> tx_level == '0)
        else $error("write while disabled reached transmit FIFO");

    flush_hold_a: assert property (
        !ctrl_enable [*2] |-> tx_empty && rx_level == '0)
        else $error("FIFO not held empty while disabled");

    window_err_a: assert property (
        psel && penable |-> pslverr == !((paddr >= 8'h60) && (paddr <= 8'hec)
            && (paddr[1:0] == 2'b00)))
        else $error("alias window decode is wrong");

    no_stray_pop_a: assert property (
        psel && penable && !hit && ctrl_enable && !rx_push |=> $stable(rx_level))
        else $error("access outside the window changed receive FIFO");

    upper_zero_a: assert property (
        prdata[31:16] == 16'h0000 ##1 prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");

    reset_value_a: assert property (
        $rose(rst_n) |-> prdata == 32'h0000_0000 && tx_empty && rx_level == '0)
        else $error("port not cleared by reset");

    // Error flag belongs to the access phase only, never to idle or setup
    err_idle_a: assert property (
        !(psel && penable) |-> !pslverr)
        else $error("error flag raised outside an access phase");

    read_stands_a: assert property (
        psel && penable |=> $stable(prdata))
        else $error("read data changed after the access phase");

    // A read of nothing must not hand back a stale entry
    empty_read_a: assert property (
        setup_rd && (rx_empty || !ctrl_enable) |=> prdata == 32'h0000_0000)
        else $error("read of an empty receive FIFO returned data");

    write_keeps_rx_a: assert property (
        psel && penable && pwrite && ctrl_enable && !rx_push |=> $stable(rx_level))
        else $error("write to the data port changed receive FIFO");

    read_keeps_tx_a: assert property (
        psel && penable && !pwrite && ctrl_enable && !tx_pop |=> $stable(tx_level))
        else $error("read of the data port changed transmit FIFO");

    rx_disabled_a: assert property (
        rx_push && !ctrl_enable |=> rx_level == '0)
        else $error("receive push landed while disabled");

    err_no_push_a: assert property (
        psel && penable && pwrite && !hit && ctrl_enable && !tx_pop
            |=> $stable(tx_level))
        else $error("refused write reached transmit FIFO");

endmodule

// ### testbench/sfd_apb_master.sv
module sfd_apb_master (
    input  wire logic        mclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge mclk) #1;
        psel = 1'b1;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(posedge mclk) #1;
        penable = 1'b1;
        @(posedge mclk);
        for (int i = 0; i < 16 && pready !== 1'b1; i++) begin
            @(posedge mclk);
        end
        rd = prdata;
        err = pslverr;
        #1;
        psel = 1'b0;
        penable = 1'b0;
        // Released lines show the inverse so a stale value cannot look valid
        paddr = ~a;
        pwdata = ~d;
    endtask
endmodule

// ### testbench/spi_fifo_data_port_test.sv
module spi_fifo_data_port_test
    import sfd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    sfd_word_t   pwdata, prdata, rd;
    logic        ctrl_enable, tx_pop, tx_empty, rx_push, rx_full, err;
    sfd_field_t  tx_data, rx_data;
    logic [3:0]  tx_level, rx_level;
    int          n_mismatch, num_checks, cyc;
    logic [7:0]  al [4] = '{8'h60, 8'h68, 8'h80, 8'hec};

    sfd_data_port i_sfd_data_port (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl_enable(ctrl_enable),
        .tx_pop(tx_pop), .tx_data(tx_data), .tx_empty(tx_empty), .tx_level(tx_level),
        .rx_push(rx_push), .rx_data(rx_data), .rx_full(rx_full), .rx_level(rx_level));
    sfd_apb_master i_sfd_apb_master (.mclk(mclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    task automatic check(input sfd_word_t seen, input sfd_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge mclk) #1;
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        check(prdata, 32'h0);
        check(32'({tx_empty, rx_full, tx_level, rx_level}), 32'h200);
        check(32'(tx_data), 32'h0);
        check(32'({pready, pslverr}), 32'h2);
        $display("Reset test done");
    endtask

    task automatic t_write();
        ctrl_enable = 1'b1;
        for (int i = 0; i < 4; i++) begin
            i_sfd_apb_master.xfer(1'b1, al[i], {16'hffff, 16'(16'h1230 + i)}, rd, err);
            check(32'(err), 32'h0);
        end
        check(32'(tx_level), 32'h4);
        for (int i = 0; i < 4; i++) begin
            check(32'(tx_data), 32'(16'h1230 + i));
            step();
            tx_pop = 1'b1;
            step();
            tx_pop = 1'b0;
        end
        check(32'(tx_empty), 32'h1);
        $display("Alias write test done");
    endtask

    task automatic t_read();
        for (int i = 0; i < 3; i++) begin
            step();
            rx_push = 1'b1;
            rx_data = 16'(16'ha5c0 + i);
        end
        step();
        rx_push = 1'b0;
        check(32'(rx_level), 32'h3);
        for (int i = 0; i < 4; i++) begin
            i_sfd_apb_master.xfer(1'b0, al[3 - i], 32'h0, rd, err);
            check(rd, (i < 3) ? 32'(16'ha5c0 + i) : 32'h0);
            check(32'(rx_level), 32'((i < 3) ? 2 - i : 0));
        end
        $display("Alias read test done");
    endtask

    task automatic t_disable();
        i_sfd_apb_master.xfer(1'b1, 8'h70, 32'h0000_0055, rd, err);
        step();
        rx_push = 1'b1;
        step();
        rx_push = 1'b0;
        check(32'({tx_level, rx_level}), 32'h11);
        rx_push = 1'b1;
        repeat (8) step();
        check(32'({rx_full, rx_level}), 32'h18);
        ctrl_enable = 1'b0;
        step();
        rx_push = 1'b0;
        check(32'({tx_level, rx_level}), 32'h0);
        i_sfd_apb_master.xfer(1'b1, 8'h74, 32'h0000_0066, rd, err);
        ctrl_enable = 1'b1;
        step();
        check(32'({tx_level, tx_empty}), 32'h1);
        $display("Disable test done");
    endtask

    task automatic t_unmapped();
        logic [7:0] bad [3] = '{8'h5c, 8'h62, 8'hf0};
        for (int i = 0; i < 3; i++) begin
            i_sfd_apb_master.xfer(1'b1, bad[i], 32'h0000_0077, rd, err);
            check(32'({err, tx_level}), 32'h10);
        end
        $display("Unmapped test done");
    endtask

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        {rst_n, ctrl_enable, tx_pop, rx_push, rx_data} = '0;
        repeat (6) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_write();
        t_read();
        t_disable();
        t_unmapped();
        wrap_up();
    end
endmodule
